/* File: design/fl_pkg.sv */
// Constants shared by the flash sequencer device and the core-side end.
// Assumes one 20 MHz system clock and a synchronous active-low reset.
`default_nettype none

package fl_pkg;
   // -----------------------------------------------------------------
   // Geometry
   // -----------------------------------------------------------------
   localparam int FL_PAGE_BYTES = 512;
   localparam int FL_SECTOR_BYTES = 1024;
   localparam int FL_PAGES = FL_SECTOR_BYTES / FL_PAGE_BYTES;
   localparam int FL_AW = $clog2(FL_SECTOR_BYTES);
   localparam int FL_PAGE_AW = $clog2(FL_PAGE_BYTES);
   localparam int FL_RAM_BYTES = 256;
   localparam int FL_RAM_AW = $clog2(FL_RAM_BYTES);
   localparam logic [15:0] FL_SHORT_LIMIT = 16'h00FF;

   // -----------------------------------------------------------------
   // Values
   // -----------------------------------------------------------------
   localparam logic [7:0] FL_ERASED = 8'hFF;
   localparam logic [7:0] FL_KEY_FIRST = 8'hA5;
   localparam logic [7:0] FL_KEY_SECOND = 8'hF1;
   localparam logic [FL_PAGE_AW-1:0] FL_IDX_LAST =
      FL_PAGE_AW'(FL_PAGE_BYTES - 1);

   // -----------------------------------------------------------------
   // Enumerations
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      FL_KEY_LOCKED = 2'b00,
      FL_KEY_HALF = 2'b01,
      FL_KEY_OPEN = 2'b10
   } fl_key_t;

   typedef enum logic [2:0] {
      FL_OP_ERASE = 3'b000,
      FL_OP_PROGRAM = 3'b001,
      FL_OP_READ_CODE = 3'b010,
      FL_OP_RAM_WRITE = 3'b011,
      FL_OP_RAM_READ = 3'b100
   } fl_op_t;

   typedef enum logic [3:0] {
      FL_H_IDLE = 4'b0000,
      FL_H_CRD = 4'b0001,
      FL_H_XRD = 4'b0010,
      FL_H_RD_WAIT = 4'b0011,
      FL_H_CTL_SET = 4'b0100,
      FL_H_KEY1 = 4'b0101,
      FL_H_KEY2 = 4'b0110,
      FL_H_TRIG = 4'b0111,
      FL_H_WAIT = 4'b1000,
      FL_H_CTL_CLR = 4'b1001
   } fl_hstate_t;
endpackage : fl_pkg

`default_nettype wire

/* File: design/fl_if.sv */
// Link between the core end and the flash sequencer device.
// Assumes both ends share one clock; strobes are one-cycle pulses.
`default_nettype none

interface fl_if;
   logic ctl_we;
   logic ctl_erase_en;
   logic ctl_write_en;
   logic key_we;
   logic [7:0] key_data;
   logic xd_we;
   logic xd_re;
   logic xd_short;
   logic [15:0] xd_addr;
   logic [7:0] xd_wdata;
   logic code_re;
   logic [15:0] code_addr;
   logic [7:0] rd_data;
   logic rd_valid;
   logic refused;
   logic busy;

   modport dev (
      input ctl_we, ctl_erase_en, ctl_write_en, key_we, key_data,
      input xd_we, xd_re, xd_short, xd_addr, xd_wdata, code_re, code_addr,
      output rd_data, rd_valid, refused, busy
   );
   modport core (
      output ctl_we, ctl_erase_en, ctl_write_en, key_we, key_data,
      output xd_we, xd_re, xd_short, xd_addr, xd_wdata, code_re, code_addr,
      input rd_data, rd_valid, refused, busy
   );
endinterface : fl_if

`default_nettype wire

/* File: design/fl_flash_dev.sv */
// Flash erase/write sequencer with its flash sector and data RAM.
// Assumes the core end sits on the same clock and keeps its own steps.
// Function
// - Erase clears a whole 512-byte page to 0xFF.
// - Unlock needs key 0xA5 then 0xF1.
// - Both enables plus write erases the page.
// - Software sets erase enable before each erase unlock.
// - One unlock per page erase.
// - Write enable alone: next write programs byte.
// - One unlock per programmed byte.
// - Programming only clears bits to zero.
// - Software checks byte erased before programming.
// - Software masks interrupts around the sequence.
// - Software clears enables after the operation.
// - Protected pages refuse erase and program.
// - Short-address writes cannot reach above 0x00FF.
// - Enabled writes go to flash storage.
// - Flash read by code reads; data reads RAM.
`default_nettype none

module fl_flash_dev
   import fl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   fl_if.dev bus,
   input wire logic [FL_PAGES-1:0] page_protect,
   output logic erase_busy,
   output logic unlocked
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] flash_mem [FL_SECTOR_BYTES];
   logic [7:0] ram_mem [FL_RAM_BYTES];

   logic erase_en;
   logic write_en;
   fl_key_t key_state;
   logic [FL_AW-FL_PAGE_AW-1:0] erase_page;
   logic [FL_PAGE_AW-1:0] erase_idx;
   logic [7:0] rd_data;
   logic rd_valid;
   logic refused;

   // ----------------------------------------------------------------
   // Target decode
   // ----------------------------------------------------------------
   function automatic logic target_ok(
      input logic [15:0] addr,
      input logic short_form,
      input logic [FL_PAGES-1:0] protect
   );
      logic ok;
      ok = 1'b1;
      if (short_form && (addr > FL_SHORT_LIMIT)) begin
         ok = 1'b0;
      end
      if (addr[15:FL_AW] != '0) begin
         ok = 1'b0;
      end
      if (protect[addr[FL_AW-1:FL_PAGE_AW]]) begin
         ok = 1'b0;
      end
      return ok;
   endfunction : target_ok

   logic flash_wr;
   logic go;
   logic [FL_AW-1:0] waddr;

   // Enabled data writes target flash, never the RAM
   assign flash_wr = bus.xd_we && write_en;
   assign go = flash_wr && (key_state == FL_KEY_OPEN) && !erase_busy &&
      target_ok(bus.xd_addr, bus.xd_short, page_protect);
   assign waddr = bus.xd_addr[FL_AW-1:0];

   // ----------------------------------------------------------------
   // Program store control
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         erase_en <= 1'b0;
         write_en <= 1'b0;
      end else if (bus.ctl_we) begin
         erase_en <= bus.ctl_erase_en;
         write_en <= bus.ctl_write_en;
      end
   end

   // ----------------------------------------------------------------
   // Unlock key sequence
   // ----------------------------------------------------------------
   // Any flash write consumes the unlock, so each page or byte needs
   // a fresh key pair; a stray key value relocks at once.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         key_state <= FL_KEY_LOCKED;
      end else if (bus.key_we) begin
         case (key_state)
            FL_KEY_LOCKED: begin
               key_state <= (bus.key_data == FL_KEY_FIRST) ?
                  FL_KEY_HALF : FL_KEY_LOCKED;
            end
            FL_KEY_HALF: begin
               key_state <= (bus.key_data == FL_KEY_SECOND) ?
                  FL_KEY_OPEN : FL_KEY_LOCKED;
            end
            default: begin
               key_state <= FL_KEY_LOCKED;
            end
         endcase
      end else if (flash_wr) begin
         key_state <= FL_KEY_LOCKED;
      end
   end

   assign unlocked = (key_state == FL_KEY_OPEN);

   // ----------------------------------------------------------------
   // Page erase walker
   // ----------------------------------------------------------------
   // One byte per clock keeps a single write port on the array, at the
   // cost of a page-length busy time.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         erase_busy <= 1'b0;
         erase_page <= '0;
         erase_idx <= '0;
      end else if (erase_busy) begin
         erase_idx <= erase_idx + 1'b1;
         if (erase_idx == FL_IDX_LAST) begin
            erase_busy <= 1'b0;
         end
      end else if (go && erase_en) begin
         erase_busy <= 1'b1;
         erase_page <= waddr[FL_AW-1:FL_PAGE_AW];
         erase_idx <= '0;
      end
   end

   // ----------------------------------------------------------------
   // Flash array writes
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (erase_busy) begin
         flash_mem[{erase_page, erase_idx}] <= FL_ERASED;
      end else if (go && !erase_en) begin
         flash_mem[waddr] <= flash_mem[waddr] & bus.xd_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Data RAM writes
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (bus.xd_we && !write_en) begin
         ram_mem[bus.xd_addr[FL_RAM_AW-1:0]] <= bus.xd_wdata;
      end
   end

   // ----------------------------------------------------------------
   // Reads
   // ----------------------------------------------------------------
   // Code reads are not taken while a page erase runs.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_data <= '0;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         if (bus.code_re && !erase_busy) begin
            rd_valid <= 1'b1;
            rd_data <= (bus.code_addr[15:FL_AW] == '0) ?
               flash_mem[bus.code_addr[FL_AW-1:0]] : FL_ERASED;
         end else if (bus.xd_re) begin
            rd_valid <= 1'b1;
            rd_data <= ram_mem[bus.xd_addr[FL_RAM_AW-1:0]];
         end
      end
   end

   // ----------------------------------------------------------------
   // Refusal flag
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         refused <= 1'b0;
      end else begin
         refused <= flash_wr && !go;
      end
   end

   assign bus.rd_data = rd_data;
   assign bus.rd_valid = rd_valid;
   assign bus.refused = refused;
   assign bus.busy = erase_busy;

endmodule : fl_flash_dev

`default_nettype wire

/* File: design/fl_core_host.sv */
// Core-side end: runs erase, program and read sequences on the link.
// Assumes the device on the link answers reads one cycle after a strobe.
`default_nettype none

module fl_core_host
   import fl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   fl_if.core bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire fl_op_t cmd_op,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_short,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_refused,
   output logic irq_hold
);

   fl_hstate_t state;
   fl_hstate_t next_state;
   fl_op_t op;
   logic [15:0] addr;
   logic [7:0] data;
   logic short_form;
   logic err;

   // ----------------------------------------------------------------
   // Sequence state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         FL_H_IDLE: begin
            if (cmd_valid) begin
               case (cmd_op)
                  FL_OP_ERASE: next_state = FL_H_CTL_SET;
                  FL_OP_PROGRAM: next_state = FL_H_CRD;
                  FL_OP_READ_CODE: next_state = FL_H_CRD;
                  FL_OP_RAM_WRITE: next_state = FL_H_TRIG;
                  default: next_state = FL_H_XRD;
               endcase
            end
         end
         FL_H_CRD: begin
            if (!bus.busy) begin
               next_state = FL_H_RD_WAIT;
            end
         end
         FL_H_XRD: next_state = FL_H_RD_WAIT;
         FL_H_RD_WAIT: begin
            if (bus.rd_valid) begin
               next_state = (op == FL_OP_PROGRAM &&
                  bus.rd_data == FL_ERASED) ? FL_H_CTL_SET : FL_H_IDLE;
            end
         end
         FL_H_CTL_SET: next_state = FL_H_KEY1;
         FL_H_KEY1: next_state = FL_H_KEY2;
         FL_H_KEY2: next_state = FL_H_TRIG;
         FL_H_TRIG: begin
            next_state = (op == FL_OP_RAM_WRITE) ? FL_H_IDLE : FL_H_WAIT;
         end
         FL_H_WAIT: begin
            if (!bus.busy) begin
               next_state = FL_H_CTL_CLR;
            end
         end
         FL_H_CTL_CLR: next_state = FL_H_IDLE;
         default: next_state = FL_H_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= FL_H_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Command capture
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op <= FL_OP_ERASE;
         addr <= '0;
         data <= '0;
         short_form <= 1'b0;
      end else if (state == FL_H_IDLE && cmd_valid) begin
         op <= cmd_op;
         addr <= cmd_addr;
         data <= cmd_data;
         short_form <= cmd_short;
      end
   end

   // A refusal pulse lands in the first wait cycle; keep it sticky.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         err <= 1'b0;
      end else if (state == FL_H_IDLE) begin
         err <= 1'b0;
      end else if (bus.refused) begin
         err <= 1'b1;
      end
   end

   // Interrupts stay masked across any flash-modifying sequence
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         irq_hold <= 1'b0;
      end else begin
         irq_hold <= (next_state != FL_H_IDLE) &&
            ((next_state == FL_H_CTL_SET) || (state != FL_H_IDLE &&
            (op == FL_OP_ERASE || op == FL_OP_PROGRAM)));
      end
   end

   // ----------------------------------------------------------------
   // Response
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_refused <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (state == FL_H_RD_WAIT && bus.rd_valid &&
               next_state == FL_H_IDLE) begin
            rsp_valid <= 1'b1;
            rsp_data <= bus.rd_data;
            rsp_refused <= (op == FL_OP_PROGRAM);
         end else if (state == FL_H_CTL_CLR ||
               (state == FL_H_TRIG && op == FL_OP_RAM_WRITE)) begin
            rsp_valid <= 1'b1;
            rsp_data <= '0;
            rsp_refused <= err || bus.refused;
         end
      end
   end

   // ----------------------------------------------------------------
   // Link drive
   // ----------------------------------------------------------------
   assign cmd_ready = (state == FL_H_IDLE);
   assign bus.ctl_we = (state == FL_H_CTL_SET) ||
      (state == FL_H_CTL_CLR);
   assign bus.ctl_erase_en = (state == FL_H_CTL_SET) &&
      (op == FL_OP_ERASE);
   assign bus.ctl_write_en = (state == FL_H_CTL_SET);
   assign bus.key_we = (state == FL_H_KEY1) || (state == FL_H_KEY2);
   assign bus.key_data = (state == FL_H_KEY1) ?
      FL_KEY_FIRST : FL_KEY_SECOND;
   assign bus.xd_we = (state == FL_H_TRIG);
   assign bus.xd_re = (state == FL_H_XRD);
   assign bus.xd_short = short_form;
   assign bus.xd_addr = addr;
   assign bus.xd_wdata = data;
   assign bus.code_re = (state == FL_H_CRD);
   assign bus.code_addr = addr;

endmodule : fl_core_host

`default_nettype wire

/* File: sim/fl_link_chk.sv */
// Checker on the link between core end and device end.
// Assumes plain link signals on one clock with synchronous reset.
`default_nettype none

module fl_link_chk
   import fl_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ctl_we,
   input wire logic ctl_erase_en,
   input wire logic ctl_write_en,
   input wire logic key_we,
   input wire logic [7:0] key_data,
   input wire logic xd_we,
   input wire logic xd_re,
   input wire logic xd_short,
   input wire logic [15:0] xd_addr,
   input wire logic code_re,
   input wire logic rd_valid,
   input wire logic refused,
   input wire logic busy
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Shadow state
   // ----------------------------------------------------------------
   logic wr_en;
   logic er_en;
   fl_key_t key;
   logic [9:0] busy_cnt;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wr_en <= 1'b0;
         er_en <= 1'b0;
      end else if (ctl_we) begin
         wr_en <= ctl_write_en;
         er_en <= ctl_erase_en;
      end
   end

   // Any flash write spends the key, taken or refused
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         key <= FL_KEY_LOCKED;
      end else if (key_we) begin
         key <= (key == FL_KEY_LOCKED && key_data == FL_KEY_FIRST) ?
            FL_KEY_HALF : (key == FL_KEY_HALF && key_data == FL_KEY_SECOND) ?
            FL_KEY_OPEN : FL_KEY_LOCKED;
      end else if (xd_we && wr_en) begin
         key <= FL_KEY_LOCKED;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         busy_cnt <= 10'h000;
      end else begin
         busy_cnt <= busy ? busy_cnt + 10'h001 : 10'h000;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_busy_bound: assert property (busy |-> busy_cnt < 10'h200)
      else $error("erase runs past one page");
   a_busy_length: assert property ($fell(busy) |-> busy_cnt == 10'h200)
      else $error("erase ended early");
   a_erase_cause: assert property ($rose(busy) |-> $past(xd_we) &&
      $past(wr_en) && $past(er_en) && $past(key) == FL_KEY_OPEN)
      else $error("erase without unlock and enables");
   a_locked_refuse: assert property
      (xd_we && wr_en && key != FL_KEY_OPEN |=> refused)
      else $error("locked flash write not refused");
   a_short_refuse: assert property
      (xd_we && wr_en && xd_short && xd_addr > FL_SHORT_LIMIT |=> refused)
      else $error("short form write above limit not refused");
   a_sector_refuse: assert property
      (xd_we && wr_en && xd_addr[15:10] != 6'h00 |=> refused)
      else $error("write outside sector not refused");
   a_busy_refuse: assert property (xd_we && wr_en && busy |=> refused)
      else $error("write during erase not refused");
   a_ram_quiet: assert property (xd_we && !wr_en |=> !refused)
      else $error("data ram write refused");
   a_code_read: assert property
      (code_re && !busy |=> rd_valid ##1 !rd_valid)
      else $error("code read answer wrong");
   a_code_wait: assert property (code_re && busy |=> !rd_valid)
      else $error("code read answered during erase");
   a_ram_read: assert property (xd_re |=> rd_valid)
      else $error("data read not answered");

   c_erase: cover property ($rose(busy));
   c_refuse: cover property (refused);
   c_prog: cover property (xd_we && wr_en && !er_en ##1 !refused);
endmodule : fl_link_chk

`default_nettype wire

/* File: sim/tb.sv */
// Bench: core end and device end joined by the link, run by commands.
// Assumes the design package, interface and both ends compile first.
`default_nettype none

module tb
   import fl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct {
      logic [7:0] data;
      logic use_data;
      logic refused;
   } fl_note_t;

   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] page_protect = 2'b00;
   logic cmd_valid = 1'b0;
   fl_op_t cmd_op = FL_OP_RAM_READ;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_short = 1'b0;
   logic cmd_ready, rsp_valid, rsp_refused, irq_hold, erase_busy, unlocked;
   logic [7:0] rsp_data;
   logic [7:0] fl_ref [0:1023];
   fl_note_t notes [$];
   logic [7:0] key_log [$];
   logic [1:0] ctl_log [$];
   logic irq_seen = 1'b0;
   logic unl_seen = 1'b0;
   int busy_cycles = 0;
   int err_total = 0;
   int tests_run = 0;

   always #25 clock = ~clock;

   fl_if u_fl_if ();
   fl_flash_dev u_fl_flash_dev (.clock(clock), .rst_n(rst_n), .bus(u_fl_if),
      .page_protect(page_protect), .erase_busy(erase_busy),
      .unlocked(unlocked));
   fl_core_host u_fl_core_host (.clock(clock), .rst_n(rst_n),
      .bus(u_fl_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
      .cmd_short(cmd_short), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_refused(rsp_refused), .irq_hold(irq_hold));
   fl_link_chk u_fl_link_chk (.clock(clock), .rst_n(rst_n),
      .ctl_we(u_fl_if.ctl_we), .ctl_erase_en(u_fl_if.ctl_erase_en),
      .ctl_write_en(u_fl_if.ctl_write_en), .key_we(u_fl_if.key_we),
      .key_data(u_fl_if.key_data), .xd_we(u_fl_if.xd_we),
      .xd_re(u_fl_if.xd_re), .xd_short(u_fl_if.xd_short),
      .xd_addr(u_fl_if.xd_addr), .code_re(u_fl_if.code_re),
      .rd_valid(u_fl_if.rd_valid), .refused(u_fl_if.refused),
      .busy(u_fl_if.busy));

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic finish_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   // Outputs and link strobes stand a full cycle, so the low phase is safe
   always @(negedge clock) begin
      fl_note_t n;
      if (irq_hold === 1'b1) irq_seen = 1'b1;
      if (unlocked === 1'b1) unl_seen = 1'b1;
      if (erase_busy === 1'b1) busy_cycles++;
      if (u_fl_if.key_we === 1'b1) key_log.push_back(u_fl_if.key_data);
      if (u_fl_if.ctl_we === 1'b1)
         ctl_log.push_back({u_fl_if.ctl_erase_en, u_fl_if.ctl_write_en});
      if (rsp_valid === 1'b1) begin
         if (notes.size() == 0) begin
            chk("spare response", 8'h01, 8'h00);
         end else begin
            n = notes.pop_front();
            chk("rsp_refused", 8'(rsp_refused), 8'(n.refused));
            if (n.use_data) chk("rsp_data", rsp_data, n.data);
         end
      end
   end

   // ----------------------------------------------------------------
   // Command tasks
   // ----------------------------------------------------------------
   task automatic run(fl_op_t op, logic [15:0] a, logic [7:0] d,
      logic s, fl_note_t n);
      notes.push_back(n);
      key_log.delete();
      ctl_log.delete();
      irq_seen = 1'b0;
      unl_seen = 1'b0;
      busy_cycles = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_short = s;
      cmd_valid = 1'b1;
      @(negedge clock);
      cmd_valid = 1'b0;
      for (int i = 0; i < 600 && cmd_ready !== 1'b1; i++) @(negedge clock);
      // A sequence that never returns to idle counts as a mismatch
      chk("cmd_ready", 8'(cmd_ready), 8'h01);
   endtask : run

   task automatic seq_chk(logic [1:0] en);
      chk("key count", 8'(key_log.size()), 8'h02);
      chk("first key", key_log[0], FL_KEY_FIRST);
      chk("second key", key_log[1], FL_KEY_SECOND);
      chk("enables set", 8'(ctl_log[0]), 8'(en));
      chk("enables clear", 8'(ctl_log[$]), 8'h00);
      chk("irq hold", 8'({irq_seen, irq_hold}), 8'h02);
      chk("unlocked", 8'({unl_seen, unlocked}), 8'h02);
   endtask : seq_chk

   task automatic rd(logic [15:0] a);
      logic [7:0] e;
      e = (a[15:10] != 6'h00) ? FL_ERASED : fl_ref[a[9:0]];
      run(FL_OP_READ_CODE, a, 8'h00, 1'b0, '{e, 1'b1, 1'b0});
   endtask : rd

   task automatic erase(logic [15:0] a, logic blk);
      run(FL_OP_ERASE, a, 8'h00, 1'b0, '{8'h00, 1'b0, blk});
      seq_chk(2'b11);
      chk("busy cycles", 8'(busy_cycles == (blk ? 0 : FL_PAGE_BYTES)),
         8'h01);
      if (!blk) begin
         for (int i = 0; i < FL_PAGE_BYTES; i++)
            fl_ref[{a[9], 9'(i)}] = FL_ERASED;
      end
   endtask : erase

   task automatic prog(logic [15:0] a, logic [7:0] d, logic s, logic blk);
      logic [7:0] old;
      old = (a[15:10] != 6'h00) ? FL_ERASED : fl_ref[a[9:0]];
      if (old !== FL_ERASED) begin
         run(FL_OP_PROGRAM, a, d, s, '{old, 1'b1, 1'b1});
      end else begin
         run(FL_OP_PROGRAM, a, d, s, '{8'h00, 1'b0, blk});
         seq_chk(2'b01);
         chk("prog busy", 8'(busy_cycles), 8'h00);
         if (!blk) fl_ref[a[9:0]] = d;
      end
      rd(a);
   endtask : prog

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      logic [15:0] a;
      logic [7:0] d;
      void'($urandom(32'h6c8b));
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         a = 16'($urandom) & 16'h00ff;
         d = 8'($urandom);
         run(FL_OP_RAM_WRITE, a, d, 1'b0, '{8'h00, 1'b0, 1'b0});
         run(FL_OP_RAM_READ, a, 8'h00, 1'b0, '{d, 1'b1, 1'b0});
      end
      erase(16'($urandom) & 16'h01ff, 1'b0);
      erase(16'h0200 | (16'($urandom) & 16'h01ff), 1'b0);
      for (int i = 0; i < 4; i++) rd(16'($urandom) & 16'h03ff);
      for (int i = 0; i < 6; i++)
         prog(16'($urandom) & 16'h03ff, 8'($urandom), 1'b0, 1'b0);
      prog(16'h0155, 8'h3c, 1'b0, 1'b0);
      prog(16'h0155, 8'hc3, 1'b0, 1'b0);
      erase(16'h0100, 1'b0);
      rd(16'h0155);
      prog(16'h0100, 8'h12, 1'b1, 1'b1);
      prog(16'h0034, 8'h56, 1'b1, 1'b0);
      prog(16'h0400, 8'h77, 1'b0, 1'b1);
      page_protect = 2'b10;
      prog(16'h0280, 8'h9a, 1'b0, 1'b1);
      erase(16'h0300, 1'b1);
      rd(16'h0300);
      page_protect = 2'b00;
      rd(a);
      run(FL_OP_RAM_READ, a, 8'h00, 1'b0, '{d, 1'b1, 1'b0});
      repeat (3) @(negedge clock);
      chk("notes left", 8'(notes.size()), 8'h00);
      finish_test();
   end

   // Three page erases dominate; this leaves a wide margin
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      finish_test();
   end
endmodule : tb

`default_nettype wire
